// [hdl/transfer_pause.sv]
// Block-gap pause and resume control with its AXI4-Lite register slave.
//
// Summary of operation
// - Bit 3 enables card interrupt detection at block gaps, 4-bit I/O only.
// - Bit 2 set holds reads via DAT2 read wait; clear stops card clock.
// - With read wait disabled, suspend and resume are not supported.
// - Writing one to the continue bit restarts a halted transfer; zero does nothing.
// - Continue clears itself when the halted direction's activity rises: data line for a read, write activity for a write.
// - Writes to the continue bit are ignored when the same write sets stop to one.
// - Stop bit halts any transfer mode at the next block gap.
// - Clearing both stop and continue never restarts the transfer.
// - Reads are halted by read wait or by stopping the card clock.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module transfer_pause (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic card_clk_pin,
    input wire logic card_dat1_pin,
    input wire logic xfer_active,
    input wire logic xfer_is_read,
    input wire logic bus_4bit,
    input wire logic card_is_io,
    input wire logic at_block_gap,
    input wire logic dat_line_active,
    input wire logic write_xfer_active,
    output logic gap_stop_req,
    output logic card_clk_hold,
    output logic dat2_o,
    output logic dat2_oe,
    output logic gap_int_sample,
    output logic suspend_ok,
    output logic irq
);

    // ************************************************************
    // Pin sampling
    // ************************************************************
    logic [1:0] pins_s;
    logic card_clk_prev_q;
    logic card_clk_rise;
    logic card_clk_fall;

    pin_sync u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({card_dat1_pin, card_clk_pin}),
        .pin_sync_out(pins_s)
    );

    // The card clock is slow against aclk, so its edges are found by sampling.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            card_clk_prev_q <= 1'b0;
        else
            card_clk_prev_q <= pins_s[0];
    end

    assign card_clk_rise = pins_s[0] & ~card_clk_prev_q;
    assign card_clk_fall = ~pins_s[0] & card_clk_prev_q;

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    logic aw_full_q;
    logic w_full_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;

    // Address and data are captured independently, in either order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_full_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_full_q <= 1'b0;
        end
    end

    assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_ctrl = wr_fire & (aw_addr_q == pause_pkg::ADDR_CTRL) & w_strb_q[0];
    assign wr_stat = wr_fire & (aw_addr_q == pause_pkg::ADDR_STAT) & w_strb_q[0];
    assign wr_mask = wr_fire & (aw_addr_q == pause_pkg::ADDR_MASK) & w_strb_q[0];

    // Ready stays low while a word is held, which gives one write at a time.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pause_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= ~aw_full_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready <= ~w_full_q & ~(s_axi_wvalid & s_axi_wready);
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                if (aw_addr_q == pause_pkg::ADDR_CTRL || aw_addr_q == pause_pkg::ADDR_STAT
                    || aw_addr_q == pause_pkg::ADDR_MASK || aw_addr_q == pause_pkg::ADDR_STATE)
                    s_axi_bresp <= pause_pkg::RESP_OKAY;
                else
                    s_axi_bresp <= pause_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    logic stop_q;
    logic cont_q;
    logic rwait_en_q;
    logic gapint_en_q;
    logic cont_done;
    pause_pkg::gap_state_t state_q;
    logic halt_read_q;
    logic dat_active_prev_q;
    logic wr_active_prev_q;
    logic dat_rise;
    logic wr_rise;

    assign dat_rise = dat_line_active & ~dat_active_prev_q;
    assign wr_rise = write_xfer_active & ~wr_active_prev_q;
    // The restart is seen on the activity flag matching the halted direction.
    assign cont_done = (state_q == pause_pkg::ST_RESUME)
        & (halt_read_q ? dat_rise : wr_rise);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dat_active_prev_q <= 1'b0;
            wr_active_prev_q <= 1'b0;
        end
        else
        begin
            dat_active_prev_q <= dat_line_active;
            wr_active_prev_q <= write_xfer_active;
        end
    end

    // Stop and the enables store what software writes; reserved bits are not kept.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stop_q <= pause_pkg::CTRL_RESET[pause_pkg::CTRL_STOP];
            rwait_en_q <= pause_pkg::CTRL_RESET[pause_pkg::CTRL_RWAIT];
            gapint_en_q <= pause_pkg::CTRL_RESET[pause_pkg::CTRL_GAPINT];
        end
        else if (wr_ctrl)
        begin
            stop_q <= w_data_q[pause_pkg::CTRL_STOP];
            rwait_en_q <= w_data_q[pause_pkg::CTRL_RWAIT];
            gapint_en_q <= w_data_q[pause_pkg::CTRL_GAPINT];
        end
    end

    // A one is accepted only when the same write leaves stop at zero, so a
    // combined cancel works; a software set wins over the self-clear.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cont_q <= pause_pkg::CTRL_RESET[pause_pkg::CTRL_CONT];
        else if (wr_ctrl && w_data_q[pause_pkg::CTRL_CONT] && !w_data_q[pause_pkg::CTRL_STOP])
            cont_q <= 1'b1;
        else if (cont_done)
            cont_q <= 1'b0;
    end

    // ************************************************************
    // Pause state machine
    // ************************************************************
    logic [2:0] events;
    logic gap_window;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= pause_pkg::ST_RUN;
            halt_read_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                pause_pkg::ST_RUN:
                begin
                    // Any transfer mode halts at the gap; DMA is not special.
                    if (stop_q && at_block_gap && xfer_active)
                    begin
                        state_q <= pause_pkg::ST_HALTED;
                        halt_read_q <= xfer_is_read;
                    end
                end
                pause_pkg::ST_HALTED:
                begin
                    // Without continue the halt holds even when stop is cleared.
                    if (cont_q && !stop_q)
                        state_q <= pause_pkg::ST_RESUME;
                end
                pause_pkg::ST_RESUME:
                begin
                    if (cont_done)
                        state_q <= pause_pkg::ST_RUN;
                end
                default:
                    state_q <= pause_pkg::ST_RUN;
            endcase
        end
    end

    // Interrupt sampling is only meaningful for a 4-bit bus to an I/O card.
    assign gap_window = gapint_en_q & bus_4bit & card_is_io & xfer_active
        & (at_block_gap | (state_q == pause_pkg::ST_HALTED));

    always_comb
    begin
        events = 3'h0;
        events[pause_pkg::EV_HALT] = (state_q == pause_pkg::ST_RUN) & stop_q
            & at_block_gap & xfer_active;
        events[pause_pkg::EV_RESUME] = cont_done;
        events[pause_pkg::EV_CARDINT] = gap_window & card_clk_rise & ~pins_s[1];
    end

    // ************************************************************
    // Card side holds
    // ************************************************************
    // Read wait changes DAT2 only on a falling card clock, so the card sees
    // a settled level at its sampling edge.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dat2_oe <= 1'b0;
            dat2_o <= 1'b0;
            card_clk_hold <= 1'b0;
            gap_stop_req <= 1'b0;
            gap_int_sample <= 1'b0;
            suspend_ok <= 1'b0;
        end
        else
        begin
            if (card_clk_fall)
                dat2_oe <= (state_q == pause_pkg::ST_HALTED) & halt_read_q & rwait_en_q;
            dat2_o <= 1'b0;
            card_clk_hold <= (state_q == pause_pkg::ST_HALTED) & halt_read_q & ~rwait_en_q;
            gap_stop_req <= stop_q;
            gap_int_sample <= gap_window;
            suspend_ok <= rwait_en_q;
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    logic [2:0] stat_q;
    logic [2:0] mask_q;

    // A new event in the cycle of a clear keeps its bit set.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stat_q <= pause_pkg::EV_RESET;
            mask_q <= pause_pkg::EV_RESET;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_stat)
                stat_q <= (stat_q & ~w_data_q[2:0]) | events;
            else
                stat_q <= stat_q | events;
            if (wr_mask)
                mask_q <= w_data_q[2:0];
            irq <= |(stat_q & mask_q);
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    // Reads answer from registers; unmapped addresses read zero with SLVERR.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= pause_pkg::RESP_OKAY;
        end
        else if (s_axi_rvalid)
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= pause_pkg::RESP_OKAY;
            if (s_axi_araddr == pause_pkg::ADDR_CTRL)
                s_axi_rdata <= {28'h0000000, gapint_en_q, rwait_en_q, cont_q, stop_q};
            else if (s_axi_araddr == pause_pkg::ADDR_STAT)
                s_axi_rdata <= {29'h00000000, stat_q};
            else if (s_axi_araddr == pause_pkg::ADDR_MASK)
                s_axi_rdata <= {29'h00000000, mask_q};
            else if (s_axi_araddr == pause_pkg::ADDR_STATE)
                s_axi_rdata <= {29'h00000000, halt_read_q, state_q};
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= pause_pkg::RESP_SLVERR;
            end
        end
        else
            s_axi_arready <= 1'b1;
    end

endmodule

// [include/pause_pkg.sv]
// Constants and types shared by the block-gap transfer pause logic.
package pause_pkg;

    // ************************************************************
    // Register indices and byte addresses
    // ************************************************************
    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_CTRL = 10'h02a;
    localparam logic [9:0] IDX_STAT = 10'h030;
    localparam logic [9:0] IDX_MASK = 10'h031;
    localparam logic [9:0] IDX_STATE = 10'h032;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [11:0] ADDR_STAT = {IDX_STAT, 2'b00};
    localparam logic [11:0] ADDR_MASK = {IDX_MASK, 2'b00};
    localparam logic [11:0] ADDR_STATE = {IDX_STATE, 2'b00};

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTRL_STOP = 0;
    localparam int CTRL_CONT = 1;
    localparam int CTRL_RWAIT = 2;
    localparam int CTRL_GAPINT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int EV_W = 3;
    localparam int EV_HALT = 0;
    localparam int EV_RESUME = 1;
    localparam int EV_CARDINT = 2;
    localparam logic [2:0] EV_RESET = 3'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // State machine
    // ************************************************************
    typedef enum logic [1:0] {ST_RUN, ST_HALTED, ST_RESUME} gap_state_t;

endpackage

// [hdl/pin_sync.sv]
// Two-flop synchroniser for the card-side pins.
`timescale 1ns/1ps
module pin_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_sync_out
);

    logic [1:0] meta_q;

    // The first stage feeds only the second; nothing else looks at it.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= 2'h0;
            pin_sync_out <= 2'h0;
        end
        else
        begin
            meta_q <= pin_in;
            pin_sync_out <= meta_q;
        end
    end

endmodule

// [bench/transfer_pause_props.sv]
// Concurrent checks on the ports of the block-gap pause logic.
`timescale 1ns/1ps
module transfer_pause_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic xfer_active,
    input wire logic bus_4bit,
    input wire logic card_is_io,
    input wire logic at_block_gap,
    input wire logic gap_stop_req,
    input wire logic card_clk_hold,
    input wire logic dat2_o,
    input wire logic dat2_oe,
    input wire logic gap_int_sample,
    input wire logic suspend_ok
);
    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Both write channels hand over at the same edge.
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    // A halted read with no write data offered, long enough for any write to land.
    sequence quiet_hold;
        (card_clk_hold && !s_axi_wvalid) [*6];
    endsequence

    a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    a_dat2_low: assert property (dat2_o == 1'b0)
        else $error("read wait drives the line high");
    a_halt_at_gap: assert property ($rose(card_clk_hold) |->
        $past(at_block_gap && gap_stop_req && xfer_active, 2))
        else $error("clock held away from a requested gap");
    a_stop_by_write: assert property ($changed(gap_stop_req) |-> $past(s_axi_bvalid))
        else $error("stop request moved without a register write");
    a_hold_kept: assert property (quiet_hold |=> card_clk_hold)
        else $error("halted transfer restarted by itself");
    a_rwait_only: assert property ($rose(dat2_oe) |-> suspend_ok && !card_clk_hold)
        else $error("read wait used while disabled");
    a_hold_no_rwait: assert property ($rose(card_clk_hold) |-> !suspend_ok)
        else $error("card clock stopped although read wait is enabled");
    a_gapint_window: assert property (gap_int_sample |->
        $past(bus_4bit && card_is_io && xfer_active))
        else $error("interrupt window open outside a 4-bit card transfer");
    a_rsvd_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
endmodule

// [bench/card_model.sv]
// Behavioural card: link clock inside frames and an interrupt on DAT1.
`timescale 1ns/1ps
module card_model (
    input wire logic frame_on,
    input wire logic int_req,
    output logic card_clk_pin,
    output logic card_dat1_pin
);
    // ************************************************************
    // Card pins
    // ************************************************************
    // The link clock stands low between frames and runs at 48 ns inside them.
    initial card_clk_pin = 1'b0;
    always #24 card_clk_pin = frame_on ? ~card_clk_pin : 1'b0;
    // DAT1 has a pull-up, so it idles high; the card pulls it low to interrupt.
    assign card_dat1_pin = int_req ? 1'b0 : 1'b1;
endmodule

// [bench/transfer_pause_test.sv]
// Self-checking bench for the block-gap pause logic.
`timescale 1ns/1ps
module transfer_pause_test;
    // ************************************************************
    // Signals
    // ************************************************************
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic xfer_active = 1'b0, xfer_is_read = 1'b0, bus_4bit = 1'b0, card_is_io = 1'b0;
    logic at_block_gap = 1'b0, dat_line_active = 1'b0, write_xfer_active = 1'b0;
    logic frame_on = 1'b0, int_req = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, card_clk_pin, card_dat1_pin;
    logic gap_stop_req, card_clk_hold, dat2_o, dat2_oe, gap_int_sample, suspend_ok, irq;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rv;
    int err_total = 0, total_checks = 0;

    always #2.5 aclk = ~aclk;

    transfer_pause dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .card_clk_pin(card_clk_pin),
        .card_dat1_pin(card_dat1_pin), .xfer_active(xfer_active), .xfer_is_read(xfer_is_read),
        .bus_4bit(bus_4bit), .card_is_io(card_is_io), .at_block_gap(at_block_gap),
        .dat_line_active(dat_line_active), .write_xfer_active(write_xfer_active),
        .gap_stop_req(gap_stop_req), .card_clk_hold(card_clk_hold), .dat2_o(dat2_o),
        .dat2_oe(dat2_oe), .gap_int_sample(gap_int_sample), .suspend_ok(suspend_ok), .irq(irq)
    );

    card_model card (
        .frame_on(frame_on), .int_req(int_req), .card_clk_pin(card_clk_pin),
        .card_dat1_pin(card_dat1_pin)
    );

    // ************************************************************
    // Bus tasks and comparison
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data are offered together; each is dropped once taken.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            aw_done = aw_done || awready;
            w_done = w_done || wready;
            if (aw_done) awvalid <= 1'b0;
            if (w_done) wvalid <= 1'b0;
        end
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
        chk(32'(bresp), 32'(pause_pkg::RESP_OKAY));
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(d, exp);
        chk(32'(r), 32'(pause_pkg::RESP_OKAY));
    endtask

    // One-cycle block boundary pulse from the data path.
    task automatic gap();
        @(posedge aclk);
        at_block_gap <= 1'b1;
        @(posedge aclk);
        at_block_gap <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ************************************************************
    // Tests
    // ************************************************************
    // The whole sequence needs a few hundred cycles; the limit of 20000 cycles is far beyond that.
    initial
    begin
        #100000;
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        conclude();
    end

    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(pause_pkg::ADDR_CTRL, 32'h0);
        axi_rd(12'h004, rv, rs);
        chk(32'(rs), 32'(pause_pkg::RESP_SLVERR));
        chk(rv, 32'h0);
        wr(pause_pkg::ADDR_CTRL, 8'hff);
        rd_chk(pause_pkg::ADDR_CTRL, 32'h0000000d);
        chk(32'(suspend_ok), 32'h1);
        // Read halted by stopping the card clock, then a stop-only clear.
        xfer_active <= 1'b1;
        xfer_is_read <= 1'b1;
        wr(pause_pkg::ADDR_CTRL, 8'h01);
        gap();
        rd_chk(pause_pkg::ADDR_STATE, 32'h5);
        chk(32'(gap_stop_req), 32'h1);
        chk(32'(card_clk_hold), 32'h1);
        chk(32'(dat2_oe), 32'h0);
        wr(pause_pkg::ADDR_MASK, 8'h01);
        rd_chk(pause_pkg::ADDR_STAT, 32'h1);
        chk(32'(irq), 32'h1);
        wr(pause_pkg::ADDR_STAT, 8'h01);
        rd_chk(pause_pkg::ADDR_STAT, 32'h0);
        chk(32'(irq), 32'h0);
        wr(pause_pkg::ADDR_CTRL, 8'h00);
        rd_chk(pause_pkg::ADDR_STATE, 32'h5);
        chk(32'(card_clk_hold), 32'h1);
        chk(32'(gap_stop_req), 32'h0);
        wr(pause_pkg::ADDR_CTRL, 8'h02);
        rd_chk(pause_pkg::ADDR_CTRL, 32'h2);
        chk(32'(card_clk_hold), 32'h0);
        dat_line_active <= 1'b1;
        rd_chk(pause_pkg::ADDR_CTRL, 32'h0);
        rd_chk(pause_pkg::ADDR_STAT, 32'h2);
        dat_line_active <= 1'b0;
        // Read halted by read wait on DAT2 while the card clock runs.
        frame_on <= 1'b1;
        wr(pause_pkg::ADDR_CTRL, 8'h05);
        gap();
        for (int i = 0; i < 60 && dat2_oe !== 1'b1; i++) @(posedge aclk);
        chk(32'(dat2_oe), 32'h1);
        chk(32'(card_clk_hold), 32'h0);
        wr(pause_pkg::ADDR_CTRL, 8'h06);
        for (int i = 0; i < 60 && dat2_oe !== 1'b0; i++) @(posedge aclk);
        chk(32'(dat2_oe), 32'h0);
        dat_line_active <= 1'b1;
        rd_chk(pause_pkg::ADDR_CTRL, 32'h4);
        // Write halted on a 4-bit I/O card that interrupts at the gap.
        xfer_is_read <= 1'b0;
        bus_4bit <= 1'b1;
        card_is_io <= 1'b1;
        int_req <= 1'b1;
        wr(pause_pkg::ADDR_STAT, 8'h07);
        wr(pause_pkg::ADDR_MASK, 8'h04);
        wr(pause_pkg::ADDR_CTRL, 8'h09);
        gap();
        rd_chk(pause_pkg::ADDR_STATE, 32'h1);
        chk(32'(gap_int_sample), 32'h1);
        chk(32'(card_clk_hold), 32'h0);
        for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge aclk);
        rd_chk(pause_pkg::ADDR_STAT, 32'h5);
        int_req <= 1'b0;
        wr(pause_pkg::ADDR_CTRL, 8'h0a);
        write_xfer_active <= 1'b1;
        rd_chk(pause_pkg::ADDR_CTRL, 32'h8);
        frame_on <= 1'b0;
        conclude();
    end
endmodule

bind transfer_pause transfer_pause_props props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .xfer_active(xfer_active), .bus_4bit(bus_4bit), .card_is_io(card_is_io),
    .at_block_gap(at_block_gap), .gap_stop_req(gap_stop_req), .card_clk_hold(card_clk_hold),
    .dat2_o(dat2_o), .dat2_oe(dat2_oe), .gap_int_sample(gap_int_sample),
    .suspend_ok(suspend_ok)
);
